// ===== rtl/ram_alarm_monitor.sv
// Summary of operation
// - declare signal loss on 32 consecutive line zeros or external loss input.
// - signal loss drives its output pin high and sets live status bit.
// - declaring signal loss sets bit 1 of interrupt status one.
// - clear loss after 32 bits without four zeros in a row, or external low.
// - clearing signal loss raises the same change interrupt again.
// - clearing signal loss resets status two bit 4 and drives pin low.
// - declare alarm when two consecutive frames each hold seven or fewer zeros.
// - alarm drives its output pin high and sets status two bit 3.
// - every alarm state change sets bit 0 of interrupt status one.
// - clear alarm when two consecutive frames each hold eight or more zeros.
// - clearing alarm drives its pin low and resets its status bit.
// - maintenance byte: failure, block error, payload kind, dependent, marker.
// - declare far failure after selectable count of frames with failure bit.
// - status one bit 4 picks three frames when zero, five when one.
// - declaring far failure sets bit 3 of interrupt status two.
// - declaring far failure sets live far failure bit in status two.
//
// Implementation choice: the Wishbone interface to the registers.
module ram_alarm_monitor (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // line interface pins
  input  wire logic        rx_pos_i,
  input  wire logic        rx_neg_i,
  input  wire logic        external_signal_loss_in_i,
  // frame timing from the framer, same clock
  input  wire logic        frame_start_i,
  input  wire logic        ma_valid_i,
  input  wire logic [7:0]  ma_byte_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // alarm pins and interrupt
  output logic             signal_loss_flag_o,
  output logic             all_ones_alarm_flag_o,
  output logic             far_failure_flag_o,
  output logic             irq_o
);

  ram_pkg::ram_state_type q;
  ram_pkg::ram_state_type d;

  always_comb begin
    logic        line_zero;
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [7:0]  rbyte;
    logic [1:0]  int1_set;
    logic [1:0]  int1_clr;
    logic        int2_set;
    logic        int2_clr;
    logic        low;
    logic [2:0]  thr;
    line_zero = 1'b0;
    req       = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    idx       = 8'h00;
    rbyte     = 8'h00;
    int1_set  = 2'h0;
    int1_clr  = 2'h0;
    int2_set  = 1'b0;
    int2_clr  = 1'b0;
    low       = 1'b0;
    thr       = 3'h0;
    d         = q;

    // pins pass two flops before any logic looks at them
    d.pos_s = {q.pos_s[0], rx_pos_i};
    d.neg_s = {q.neg_s[0], rx_neg_i};
    d.ext_s = {q.ext_s[0], external_signal_loss_in_i};
    line_zero = ~(q.pos_s[1] | q.neg_s[1]);

    if (line_zero) begin
      if (q.zero_run != ram_pkg::RAM_LOS_ZERO_RUN) begin
        d.zero_run = q.zero_run + 6'h01;
      end
    end else begin
      d.zero_run = 6'h00;
    end
    if (d.zero_run == ram_pkg::RAM_LOS_ZERO_RUN) begin
      d.int_los = 1'b1;
    end

    // span restarts whenever four zeros in a row are seen
    if (line_zero) begin
      if (q.short_run != ram_pkg::RAM_LOS_CLR_RUN) begin
        d.short_run = q.short_run + 3'h1;
      end
    end else begin
      d.short_run = 3'h0;
    end
    if (d.short_run == ram_pkg::RAM_LOS_CLR_RUN) begin
      d.span = 6'h00;
    end else if (q.span != ram_pkg::RAM_LOS_CLR_SPAN) begin
      d.span = q.span + 6'h01;
    end
    if (q.int_los && d.span == ram_pkg::RAM_LOS_CLR_SPAN) begin
      d.int_los = 1'b0;
    end
    // external input also declares; its fall clears it
    d.los = d.int_los | q.ext_s[1];

    // zeros per frame, saturating just above the alarm limit
    if (frame_start_i) begin
      low        = (q.frm_zeros <= ram_pkg::RAM_AIS_MAX_ZERO);
      d.prev_low = low;
      d.frm_zeros = line_zero ? 4'h1 : 4'h0;
      // two low-zero frames in a row declare
      if (low && q.prev_low) begin
        d.ais = 1'b1;
      end
      // two high-zero frames in a row clear
      if (!low && !q.prev_low) begin
        d.ais = 1'b0;
      end
    end else if (line_zero && q.frm_zeros != ram_pkg::RAM_AIS_ZERO_SAT) begin
      d.frm_zeros = q.frm_zeros + 4'h1;
    end

    thr = q.ferf_sel ? ram_pkg::RAM_FERF_LONG : ram_pkg::RAM_FERF_SHORT;
    if (ma_valid_i) begin
      d.pld_kind = ma_byte_i[ram_pkg::RAM_MA_PLD_MSB:ram_pkg::RAM_MA_PLD_LSB];
      d.tmark    = ma_byte_i[ram_pkg::RAM_MA_TMARK];
      if (ma_byte_i[ram_pkg::RAM_MA_FERF]) begin
        d.ferf_zeros = 3'h0;
        if (q.ferf_ones != ram_pkg::RAM_FERF_LONG) begin
          d.ferf_ones = q.ferf_ones + 3'h1;
        end
        if (d.ferf_ones >= thr) begin
          d.ferf = 1'b1;
        end
      end else begin
        d.ferf_ones = 3'h0;
        if (q.ferf_zeros != ram_pkg::RAM_FERF_LONG) begin
          d.ferf_zeros = q.ferf_zeros + 3'h1;
        end
        if (d.ferf_zeros >= thr) begin
          d.ferf = 1'b0;
        end
      end
    end

    int1_set[ram_pkg::RAM_INT1_LOS] = d.los ^ q.los;
    int1_set[ram_pkg::RAM_INT1_AIS] = d.ais ^ q.ais;
    int2_set = d.ferf ^ q.ferf;

    // wishbone classic: one wait state, ack for one cycle
    req   = wb_cyc_i & wb_stb_i & ~q.ack;
    wr    = req & wb_we_i & wb_sel_i[0];
    rd    = req & ~wb_we_i;
    idx   = wb_adr_i[9:2];
    d.ack = req;

    unique case (idx)
      ram_pkg::RAM_IDX_CFG1: begin
        rbyte[7:5] = q.pld_kind;
        rbyte[ram_pkg::RAM_CFG1_FERF_SEL]  = q.ferf_sel;
        rbyte[ram_pkg::RAM_CFG1_TMARK_SEL] = q.tmark_sel;
        if (wr) begin
          d.ferf_sel  = wb_dat_i[ram_pkg::RAM_CFG1_FERF_SEL];
          d.tmark_sel = wb_dat_i[ram_pkg::RAM_CFG1_TMARK_SEL];
        end
      end
      ram_pkg::RAM_IDX_CFG2: begin
        rbyte[ram_pkg::RAM_CFG2_LOF_SEL] = q.lof_sel;
        // live loss bit; drops with the condition
        rbyte[ram_pkg::RAM_CFG2_LOS]     = q.los;
        // live alarm bit; drops with the condition
        rbyte[ram_pkg::RAM_CFG2_AIS]     = q.ais;
        rbyte[ram_pkg::RAM_CFG2_TMARK]   = q.tmark;
        rbyte[ram_pkg::RAM_CFG2_FERF]    = q.ferf;
        if (wr) begin
          d.lof_sel = wb_dat_i[ram_pkg::RAM_CFG2_LOF_SEL];
        end
      end
      ram_pkg::RAM_IDX_INT1: begin
        rbyte[1:0] = q.int1;
        // read clears, write of one clears too
        if (rd) begin
          int1_clr = 2'h3;
        end
        if (wr) begin
          int1_clr = wb_dat_i[1:0];
        end
      end
      ram_pkg::RAM_IDX_INT2: begin
        rbyte[ram_pkg::RAM_INT2_FERF] = q.int2_ferf;
        if (rd) begin
          int2_clr = 1'b1;
        end
        if (wr) begin
          int2_clr = wb_dat_i[ram_pkg::RAM_INT2_FERF];
        end
      end
      ram_pkg::RAM_IDX_MASK1: begin
        rbyte[1:0] = q.mask1;
        if (wr) begin
          d.mask1 = wb_dat_i[1:0];
        end
      end
      ram_pkg::RAM_IDX_MASK2: begin
        rbyte[ram_pkg::RAM_INT2_FERF] = q.mask2;
        if (wr) begin
          d.mask2 = wb_dat_i[ram_pkg::RAM_INT2_FERF];
        end
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase

    // a new event in the clearing cycle is kept: set beats clear
    d.int1      = (q.int1 & ~int1_clr) | int1_set;
    d.int2_ferf = (q.int2_ferf & ~int2_clr) | int2_set;
    d.rdata     = req ? {24'h000000, rbyte} : 32'h00000000;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // loss pin follows the live state
  assign signal_loss_flag_o    = q.los;
  // alarm pin follows the live state
  assign all_ones_alarm_flag_o = q.ais;
  assign far_failure_flag_o    = q.ferf;
  assign wb_ack_o              = q.ack;
  assign wb_dat_o              = q.rdata;
  assign irq_o = (|(q.int1 & q.mask1)) | (q.int2_ferf & q.mask2);

endmodule

// ===== rtl/ram_pkg.sv
package ram_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RAM_IDX_CFG1  = 8'h10;
  localparam logic [7:0] RAM_IDX_CFG2  = 8'h11;
  localparam logic [7:0] RAM_IDX_INT2  = 8'h13;
  localparam logic [7:0] RAM_IDX_INT1  = 8'h14;
  localparam logic [7:0] RAM_IDX_MASK1 = 8'h16;
  localparam logic [7:0] RAM_IDX_MASK2 = 8'h17;

  // field positions, config and status one
  localparam int RAM_CFG1_PLD_LSB   = 5;
  localparam int RAM_CFG1_FERF_SEL  = 4;
  localparam int RAM_CFG1_TMARK_SEL = 3;
  // config and status two
  localparam int RAM_CFG2_LOF_SEL   = 7;
  localparam int RAM_CFG2_LOS       = 4;
  localparam int RAM_CFG2_AIS       = 3;
  localparam int RAM_CFG2_TMARK     = 1;
  localparam int RAM_CFG2_FERF      = 0;
  // interrupt status one and two, and the masks of same layout
  localparam int RAM_INT1_LOS       = 1;
  localparam int RAM_INT1_AIS       = 0;
  localparam int RAM_INT2_FERF      = 3;
  // maintenance and adaptation byte
  localparam int RAM_MA_FERF        = 7;
  localparam int RAM_MA_FEBE        = 6;
  localparam int RAM_MA_PLD_MSB     = 5;
  localparam int RAM_MA_PLD_LSB     = 3;
  localparam int RAM_MA_TMARK       = 0;

  // detection counts
  localparam logic [5:0] RAM_LOS_ZERO_RUN = 6'h20;
  localparam logic [5:0] RAM_LOS_CLR_SPAN = 6'h20;
  localparam logic [2:0] RAM_LOS_CLR_RUN  = 3'h4;
  localparam logic [3:0] RAM_AIS_MAX_ZERO = 4'h7;
  localparam logic [3:0] RAM_AIS_ZERO_SAT = 4'h8;
  localparam logic [2:0] RAM_FERF_SHORT   = 3'h3;
  localparam logic [2:0] RAM_FERF_LONG    = 3'h5;

  // reset values
  localparam logic [7:0] RAM_CFG1_RST  = 8'h00;
  localparam logic [7:0] RAM_CFG2_RST  = 8'h00;
  localparam logic [1:0] RAM_MASK1_RST = 2'h0;
  localparam logic       RAM_MASK2_RST = 1'b0;

  typedef struct packed {
    logic [1:0]  pos_s;
    logic [1:0]  neg_s;
    logic [1:0]  ext_s;
    logic [5:0]  zero_run;
    logic [5:0]  span;
    logic [2:0]  short_run;
    logic        int_los;
    logic        los;
    logic [3:0]  frm_zeros;
    logic        prev_low;
    logic        ais;
    logic [2:0]  ferf_ones;
    logic [2:0]  ferf_zeros;
    logic        ferf;
    logic [2:0]  pld_kind;
    logic        tmark;
    logic        ferf_sel;
    logic        tmark_sel;
    logic        lof_sel;
    logic [1:0]  int1;
    logic        int2_ferf;
    logic [1:0]  mask1;
    logic        mask2;
    logic        ack;
    logic [31:0] rdata;
  } ram_state_type;

endpackage

// ===== bench/ram_alarm_props.sv
module ram_alarm_props (
  // clock, reset, line and frame
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        rx_pos_i,
  input wire logic        rx_neg_i,
  input wire logic        external_signal_loss_in_i,
  input wire logic        frame_start_i,
  input wire logic        ma_valid_i,
  input wire logic [7:0]  ma_byte_i,
  // bus and alarm pins
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        signal_loss_flag_o,
  input wire logic        all_ones_alarm_flag_o,
  input wire logic        far_failure_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] zrun_q;
  logic [2:0] ones_q;
  logic       sel5_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // counts saturate so a long idle line cannot wrap back to a match
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      zrun_q <= 6'h00;
      ones_q <= 3'h0;
      sel5_q <= 1'b0;
    end else begin
      zrun_q <= (rx_pos_i | rx_neg_i) ? 6'h00 : zrun_q + {5'h00, ~&zrun_q};
      if (ma_valid_i)
        ones_q <= ma_byte_i[7] ? ones_q + {2'h0, ~&ones_q} : 3'h0;
      if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == 8'h10)
        sel5_q <= wb_dat_i[4];
    end
  end
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_data_idle: assert property (wb_ack_o || wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  a_loss_zero: assert property (
    zrun_q == 6'h20 |-> ##[1:6] signal_loss_flag_o)
    else $error("zero run did not raise loss flag");
  a_loss_ext: assert property (
    external_signal_loss_in_i [*5] |=> signal_loss_flag_o)
    else $error("loss flag low while external loss held");
  a_alarm_frame: assert property (
    $changed(all_ones_alarm_flag_o) |-> $past(frame_start_i))
    else $error("alarm flag moved off a frame boundary");
  a_far_count: assert property (
    $rose(far_failure_flag_o) |-> ones_q == (sel5_q ? 3'h5 : 3'h3))
    else $error("far failure declared at wrong frame count");
  a_far_clear: assert property (
    $fell(far_failure_flag_o) |-> $past(ma_valid_i) && ones_q == 3'h0)
    else $error("far failure cleared without clean byte");
  c_loss: cover property ($rose(signal_loss_flag_o));
  c_alarm: cover property ($fell(all_ones_alarm_flag_o));
  c_far: cover property ($fell(far_failure_flag_o));
endmodule

bind ram_alarm_monitor ram_alarm_props u_ram_alarm_props (.*);

// ===== bench/ram_line_model.sv
module ram_line_model (
  // clock and stimulus
  input  wire logic       clk_i,
  input  wire logic [5:0] nz_i,
  input  wire logic [7:0] ma_i,
  // line and frame outputs
  output logic            pos_o,
  output logic            neg_o,
  output logic            frame_start_o,
  output logic            ma_valid_o,
  output logic [7:0]      ma_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] k_q;
  logic       ph_q;
  logic       one;
  // short 64-bit frames; zeros on even slots never form a run of four
  assign one = !(nz_i > 6'h20 || (!k_q[0] && {1'b0, k_q} < {nz_i, 1'b0}));
  initial begin
    {k_q, ph_q, pos_o, neg_o, frame_start_o, ma_valid_o, ma_byte_o} = '0;
  end
  always @(posedge clk_i) begin
    k_q <= k_q + 6'h01;
    ph_q <= ph_q ^ one;
    pos_o <= one & ph_q;
    neg_o <= one & !ph_q;
    frame_start_o <= k_q == 6'h00;
    ma_valid_o <= k_q == 6'h08;
    // stale byte scrambled so nothing leans on its last value
    ma_byte_o <= k_q == 6'h08 ? ma_i : ~ma_byte_o;
  end
endmodule

// ===== bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i, rst_i, rx_pos_i, rx_neg_i, frame_start_i;
  logic        external_signal_loss_in_i, ma_valid_i, wb_ack_o, irq_o;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, signal_loss_flag_o;
  logic        all_ones_alarm_flag_o, far_failure_flag_o;
  logic [7:0]  ma_byte_i, ma, rd;
  logic [5:0]  nz;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  int          miscompares, checks_done;
  ram_alarm_monitor u_ram_alarm_monitor (.*);
  ram_line_model u_ram_line_model (.clk_i(core_clk_i), .nz_i(nz),
    .ma_i(ma), .pos_o(rx_pos_i), .neg_o(rx_neg_i),
    .frame_start_o(frame_start_i), .ma_valid_o(ma_valid_i),
    .ma_byte_o(ma_byte_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic frames(input int n);
    repeat (n) do @(posedge core_clk_i); while (ma_valid_i !== 1'b1);
  endtask
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    cyc(1);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_dat_i, ma, external_signal_loss_in_i} = '0;
    {wb_sel_i, nz, miscompares, checks_done} = {4'hF, 6'h20, 64'h0};
    cyc(4);
    rst_i <= 1'b0;
    cyc(1);
    rdchk(8'h10, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h13, 8'h00);
    rdchk(8'h14, 8'h00);
    rdchk(8'h20, 8'h00);
    wb(1'b1, 8'h10, 8'hFF);
    rdchk(8'h10, 8'h18);
    nz <= 6'h21;
    cyc(40);
    chk(signal_loss_flag_o, 8'h01);
    rdchk(8'h11, 8'h10);
    chk(irq_o, 8'h00);
    wb(1'b1, 8'h16, 8'h02);
    chk(irq_o, 8'h01);
    wb(1'b1, 8'h16, 8'h00);
    rdchk(8'h14, 8'h02);
    rdchk(8'h14, 8'h00);
    chk(irq_o, 8'h00);
    rdchk(8'h11, 8'h10);
    nz <= 6'h20;
    cyc(45);
    chk(signal_loss_flag_o, 8'h00);
    rdchk(8'h14, 8'h02);
    rdchk(8'h11, 8'h00);
    external_signal_loss_in_i <= 1'b1;
    cyc(6);
    chk(signal_loss_flag_o, 8'h01);
    external_signal_loss_in_i <= 1'b0;
    cyc(6);
    chk(signal_loss_flag_o, 8'h00);
    rdchk(8'h14, 8'h02);
    // seven zeros a frame is the last count that still means all ones
    nz <= 6'h07;
    frames(4);
    cyc(2);
    chk(all_ones_alarm_flag_o, 8'h01);
    rdchk(8'h11, 8'h08);
    rdchk(8'h14, 8'h01);
    nz <= 6'h08;
    frames(4);
    cyc(2);
    chk(all_ones_alarm_flag_o, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h14, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, 8'h10, s ? 8'h10 : 8'h00);
      frames(1);
      ma <= 8'hA8;
      frames(s ? 4 : 2);
      cyc(2);
      chk(far_failure_flag_o, 8'h00);
      frames(1);
      cyc(2);
      chk(far_failure_flag_o, 8'h01);
      chk(irq_o, 8'h00);
      wb(1'b1, 8'h17, 8'h08);
      chk(irq_o, 8'h01);
      wb(1'b1, 8'h17, 8'h00);
      rdchk(8'h13, 8'h08);
      rdchk(8'h11, 8'h01);
      rdchk(8'h10, s ? 8'hB0 : 8'hA0);
      ma <= 8'h28;
      frames(s ? 5 : 3);
      cyc(2);
      chk(far_failure_flag_o, 8'h00);
      rdchk(8'h13, 8'h08);
    end
    close_out();
  end
endmodule
